// ---- bench/card_model.sv ----
// card side model: supply supervisor answer and open-drain card line
`timescale 1ns/1ps

module card_model (
	// supply control from the sequencer
	input wire vcc_en,
	input wire vcc_broken,
	input wire slow,
	output logic vcc_valid,
	// card line: sequencer or card pull low, pull-up otherwise
	input wire card_oe,
	input wire card_pull,
	output wire card_line
);
	// supply settles late but inside the first step; a broken one never
	always @(vcc_en or vcc_broken) begin
		if (!vcc_en || vcc_broken)
			vcc_valid = 1'h0;
		else
			vcc_valid <= #(slow ? 400 : 100) 1'h1;
	end
	// released line floats to the pull-up level
	assign card_line = !(card_oe || card_pull);
endmodule

// ---- bench/card_session_seq_checker.sv ----
// concurrent checks on the session sequencer ports
`timescale 1ns/1ps

module seq_checker #(
	parameter integer STEP_OSC_CYCLES = 64
) (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_N,
	// host and supervisor pins
	input wire ACTIVATION_REQUEST_N,
	input wire CARD_VOLTAGE_SELECT,
	input wire CARD_DETECT_IN,
	input wire LOGIC_SUPPLY_FAULT,
	input wire CARD_OVERCURRENT,
	// card side
	input wire CARD_VCC_EN,
	input wire CARD_VCC_5V_SEL,
	input wire CARD_RST,
	input wire CARD_CLK,
	input wire CARD_IO_OE,
	input wire HOST_IO_OE,
	input wire STATUS_OFF_N_OE
);
	// one step of oscillator edges at 8 core cycles each, plus sync slack
	localparam int RST_MAX = (STEP_OSC_CYCLES + 2) * 8 + 8;
	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_fault_seen;
		(CARD_VCC_EN && !ACTIVATION_REQUEST_N && CARD_OVERCURRENT)[*3];
	endsequence
	// long enough for the detect pin to pass the synchronisers
	sequence s_idle_steady;
		(ACTIVATION_REQUEST_N && !CARD_VCC_EN && $stable(CARD_DETECT_IN))[*6];
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_clk_needs_vcc: assert property (!CARD_VCC_EN |-> !CARD_CLK)
		else $error("card clock running without card supply");
	chk_rst_needs_vcc: assert property (CARD_RST |-> CARD_VCC_EN)
		else $error("card reset high without card supply");
	chk_rx_needs_vcc: assert property (!CARD_IO_OE |-> CARD_VCC_EN)
		else $error("card line released without card supply");
	chk_host_idle: assert property (!CARD_VCC_EN |-> !HOST_IO_OE)
		else $error("host line driven outside session");
	chk_idle_status: assert property (s_idle_steady |-> STATUS_OFF_N_OE == !CARD_DETECT_IN)
		else $error("idle status does not show card presence");
	chk_fault_status: assert property (s_fault_seen |-> ##[0:3] STATUS_OFF_N_OE)
		else $error("status not pulled low on session fault");
	chk_fault_deact: assert property (s_fault_seen |-> ##[1:RST_MAX] !CARD_RST)
		else $error("card reset not dropped after fault");
	chk_vcc_start: assert property ($rose(CARD_VCC_EN) |-> !$past(ACTIVATION_REQUEST_N, 2)
		&& $past(CARD_DETECT_IN, 2) && !$past(LOGIC_SUPPLY_FAULT, 2))
		else $error("card supply rose without a valid request");
	chk_vsel_level: assert property ((CARD_VCC_EN && $stable(CARD_VOLTAGE_SELECT))[*8]
		|-> CARD_VCC_5V_SEL == CARD_VOLTAGE_SELECT)
		else $error("card supply level differs from select pin");
endmodule

bind card_session_seq seq_checker #(.STEP_OSC_CYCLES(STEP_OSC_CYCLES)) chk_u (.*);

// ---- bench/card_session_seq_tb_top.sv ----
// self-checking bench for the smart card session sequencer
`timescale 1ns/1ps

module card_session_seq_tb_top;
	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic CORE_CLK = 1'h0, RST_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0;
	logic ACTIVATION_REQUEST_N = 1'h1, CARD_VOLTAGE_SELECT = 1'h1, CARD_RESET_REQUEST_IN = 1'h0;
	logic CLOCK_DIVIDE_SEL_HI = 1'h1, CLOCK_DIVIDE_SEL_LO = 1'h1, OSCILLATOR_INPUT = 1'h0;
	logic CARD_DETECT_IN = 1'h0, LOGIC_SUPPLY_FAULT = 1'h1, CARD_OVERCURRENT = 1'h0;
	logic broken = 1'h0, slow = 1'h0, cpull = 1'h0, hpull = 1'h0;
	logic [3:0] REG_ADDR = 4'h0;
	logic [7:0] REG_WDATA = 8'h00, rdat;
	wire [7:0] REG_RDATA;
	wire IRQ, CARD_VCC_EN, CARD_VCC_5V_SEL, CARD_RST, CARD_CLK, CARD_IO_O, CARD_IO_OE;
	wire HOST_IO_O, HOST_IO_OE, STATUS_OFF_N_O, STATUS_OFF_N_OE, CARD_VCC_VALID, CARD_IO_I;
	// host line is open drain with a pull-up
	wire HOST_IO_I = !(HOST_IO_OE || hpull);
	int fails = 0, checked = 0;

	initial forever #12.5 CORE_CLK = ~CORE_CLK;
	// offset phase so oscillator edges never line up with the core clock
	initial begin
		#37;
		forever #100 OSCILLATOR_INPUT = ~OSCILLATOR_INPUT;
	end

	card_model model_u (.vcc_en(CARD_VCC_EN), .vcc_broken(broken), .slow(slow),
		.vcc_valid(CARD_VCC_VALID), .card_oe(CARD_IO_OE), .card_pull(cpull),
		.card_line(CARD_IO_I));
	// short hold-off and steps keep the run brief
	card_session_seq #(.HOLDOFF_CYCLES(50), .STEP_OSC_CYCLES(4)) dut_u (.*);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask
	function logic sig(input int s);
		case (s)
			0: return CARD_VCC_EN;
			1: return CARD_IO_OE;
			2: return CARD_CLK;
			default: return STATUS_OFF_N_OE;
		endcase
	endfunction
	// bounded wait; running out ends the run
	task wt(input int s, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && sig(s) !== v; i++)
			@(posedge CORE_CLK);
		checked++;
		if (sig(s) !== v) begin
			fails++;
			$display("BAD wait %0d exp %b got %b", s, v, sig(s));
			close_out;
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge CORE_CLK);
		REG_WR <= 1'h0;
		@(posedge CORE_CLK);
	endtask
	task rd(input logic [3:0] a);
		REG_ADDR <= a;
		REG_RD <= 1'h1;
		@(posedge CORE_CLK);
		REG_RD <= 1'h0;
		@(posedge CORE_CLK);
		rdat = REG_RDATA;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task regs;
		rd(4'h4);
		chk("mask reset", rdat, 8'h00);
		wr(4'h4, 8'h0F);
		rd(4'h4);
		chk("mask", rdat, 8'h0F);
		rd(4'h2);
		chk("unmapped", rdat, 8'h00);
	endtask
	task holdoff;
		CARD_DETECT_IN <= 1'h1;
		LOGIC_SUPPLY_FAULT <= 1'h0;
		tick(8);
		chk("status card", STATUS_OFF_N_OE, 0);
		chk("irq detect", IRQ, 1);
		wr(4'h0, 8'h0F);
		tick(2);
		chk("irq cleared", IRQ, 0);
		ACTIVATION_REQUEST_N <= 1'h0;
		tick(30);
		chk("vcc in hold-off", CARD_VCC_EN, 0);
		ACTIVATION_REQUEST_N <= 1'h1;
		tick(60);
	endtask
	task idle_fault;
		CARD_OVERCURRENT <= 1'h1;
		tick(10);
		chk("idle fault status", STATUS_OFF_N_OE, 0);
		chk("idle fault vcc", CARD_VCC_EN, 0);
		CARD_OVERCURRENT <= 1'h0;
		tick(2);
		// the inhibit bit must refuse an otherwise valid request
		wr(4'hC, 8'h01);
		ACTIVATION_REQUEST_N <= 1'h0;
		tick(20);
		chk("inhibited vcc", CARD_VCC_EN, 0);
		ACTIVATION_REQUEST_N <= 1'h1;
		wr(4'hC, 8'h00);
		tick(4);
	endtask
	task act(input logic rq);
		CARD_RESET_REQUEST_IN <= rq;
		ACTIVATION_REQUEST_N <= 1'h0;
		wt(0, 1, 12);
		chk("vcc level", CARD_VCC_5V_SEL, CARD_VOLTAGE_SELECT);
		wt(1, 0, 120);
		chk("clk before third", CARD_CLK, 0);
		if (rq) begin
			tick(150);
			chk("clk held", CARD_CLK, 0);
			chk("rst held", CARD_RST, 0);
			CARD_RESET_REQUEST_IN <= 1'h0;
		end
		wt(2, 1, 150);
		CARD_RESET_REQUEST_IN <= 1'h1;
		tick(6);
		chk("rst follows", CARD_RST, 1);
		rd(4'h0);
		chk("session event", rdat[0], 1);
		chk("irq session", IRQ, 1);
		rd(4'h8);
		chk("state on", rdat, 8'hF5);
	endtask
	task io;
		hpull <= 1'h1;
		tick(8);
		chk("card copy", CARD_IO_OE, 1);
		chk("host input", HOST_IO_OE, 0);
		hpull <= 1'h0;
		tick(8);
		chk("card neutral", CARD_IO_OE, 0);
		cpull <= 1'h1;
		tick(8);
		chk("host copy", HOST_IO_OE, 1);
		cpull <= 1'h0;
		tick(8);
		chk("host neutral", HOST_IO_OE, 0);
	endtask
	task divs;
		int s, n, k, d;
		logic p;
		for (s = 0; s < 4; s++) begin
			{CLOCK_DIVIDE_SEL_HI, CLOCK_DIVIDE_SEL_LO} <= s[1:0];
			d = (s == 2) ? 1 : 8 >> ((s == 3) ? 2 : s);
			tick(40);
			n = 0;
			p = CARD_CLK;
			// 512 core cycles hold exactly 64 oscillator periods
			for (k = 0; k < 512; k++) begin
				@(posedge CORE_CLK);
				if (CARD_CLK && !p)
					n++;
				p = CARD_CLK;
			end
			chk("card clk rate", n >= 64 / d - 1 && n <= 64 / d + 1, 1);
		end
	endtask
	task deact;
		int t, tr, tc, ti;
		t = 0;
		tr = 0;
		tc = 0;
		ti = 0;
		ACTIVATION_REQUEST_N <= 1'h1;
		while (CARD_VCC_EN && t < 400) begin
			@(posedge CORE_CLK);
			t++;
			if (CARD_RST) tr = t;
			if (CARD_CLK) tc = t;
			if (!CARD_IO_OE) ti = t;
		end
		chk("vcc off", CARD_VCC_EN, 0);
		chk("deact order", tr < tc && tc < ti && ti < t, 1);
		wr(4'h4, 8'h00);
		tick(2);
		chk("irq masked", IRQ, 0);
		wr(4'h0, 8'h0F);
		wr(4'h4, 8'h0F);
	endtask
	task bad_vcc;
		broken <= 1'h1;
		ACTIVATION_REQUEST_N <= 1'h0;
		wt(0, 1, 12);
		wt(0, 0, 60);
		chk("vcc fault status", STATUS_OFF_N_OE, 1);
		chk("no reception", CARD_IO_OE, 1);
		broken <= 1'h0;
		ACTIVATION_REQUEST_N <= 1'h1;
		tick(8);
		chk("status cleared", STATUS_OFF_N_OE, 0);
	endtask
	task faults;
		int k;
		for (k = 0; k < 3; k++) begin
			act(0);
			if (k == 0) CARD_OVERCURRENT <= 1'h1;
			if (k == 1) CARD_DETECT_IN <= 1'h0;
			if (k == 2) LOGIC_SUPPLY_FAULT <= 1'h1;
			wt(3, 1, 6);
			wt(0, 0, 200);
			CARD_OVERCURRENT <= 1'h0;
			CARD_DETECT_IN <= 1'h1;
			LOGIC_SUPPLY_FAULT <= 1'h0;
			ACTIVATION_REQUEST_N <= 1'h1;
			tick(70);
			chk("status after fault", STATUS_OFF_N_OE, 0);
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		tick(20);
		chk("card io low", CARD_IO_OE, 1);
		chk("host io high", HOST_IO_OE, 0);
		chk("open drain data", {CARD_IO_O, HOST_IO_O, STATUS_OFF_N_O}, 0);
		RST_N <= 1'h1;
		regs;
		holdoff;
		idle_fault;
		act(0);
		io;
		divs;
		deact;
		CARD_VOLTAGE_SELECT <= 1'h0;
		slow <= 1'h1;
		act(1);
		deact;
		bad_vcc;
		faults;
		close_out;
	end
endmodule

// ---- rtl/card_seq_defs.vh ----
// constants shared by the smart card session sequencer files
`ifndef CARD_SEQ_DEFS_VH
`define CARD_SEQ_DEFS_VH

// ----------------------------------------------------------------
// synchronised pin vector: bit positions and pull default values
// ----------------------------------------------------------------
`define SYNC_W 12
`define B_ACT 0
`define B_RSTREQ 1
`define B_VSEL 2
`define B_DIV_HI 3
`define B_DIV_LO 4
`define B_OSC 5
`define B_DET 6
`define B_LOGIC_SUPPLY_FAULT_THRESHOLD 7
`define B_OC 8
`define B_VCCOK 9
`define B_CIO 10
`define B_HIO 11
`define SYNC_INIT 12'h89D

// ----------------------------------------------------------------
// register offsets and event bits
// ----------------------------------------------------------------
`define A_STAT 4'h0
`define A_MASK 4'h4
`define A_STATE 4'h8
`define A_CTRL 4'hC
`define STAT_W 4
`define EV_ACT 0
`define EV_DEACT 1
`define EV_FAULT 2
`define EV_CARD 3
`define CTRL_INHIBIT 0

// ----------------------------------------------------------------
// card clock division selects {hi, lo}
// ----------------------------------------------------------------
`define DIV8 2'h0
`define DIV4 2'h1
`define DIV1 2'h2
`define DIV2 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HOLDOFF_MS 10
`define CORE_CLK_KHZ 40000
`define STEP_OSC 64

`endif

// ---- rtl/card_session_seq.v ----
// smart card session sequencer: clock divider, hold-off, activation, status
//
// Contract
// - card clock is oscillator divided by 8, 4, 1 or 2 per two select pins.
// - activation requests are refused for 10 ms after logic supply becomes good.
// - activation starts on request falling edge, only with card present and supply good.
// - card VCC rises at selected level, checked after first interval; invalid shuts off.
// - reset request low at start: reception at second interval, clock at third; code enables reception after the first interval, the clock after the third.
// - reset request high at start: clock starts on its falling edge, then reset follows.
// - host deactivates by raising request; device may deactivate on its own.
// - over-current, supply fault, VCC fault or card removal in session deactivate.
// - deactivation drops reset, then clock, then i/o, then VCC, interval by interval.
// - outside a session status shows card presence only; faults ignored.
// - in session extraction or fault pulls status low and starts deactivation together.
// - after reset card i/o held low, host i/o high until reception enabled.
// - first line with falling edge becomes input; other line copies it.
// - rising edge on the input line returns both lines to neutral.
// - open inputs default: request, voltage and divide selects high; others low; the synchronisers reset supply fault and host i/o high as well.
// - voltage select high chooses 5 V, low chooses 3 V.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "card_seq_defs.vh"

module card_session_seq #(
	parameter integer HOLDOFF_CYCLES = `HOLDOFF_MS * `CORE_CLK_KHZ,
	parameter integer STEP_OSC_CYCLES = `STEP_OSC
) (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_N,
	// register port
	input wire [3:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	output reg IRQ,
	// host control pins
	input wire ACTIVATION_REQUEST_N,
	input wire CARD_RESET_REQUEST_IN,
	input wire CARD_VOLTAGE_SELECT,
	input wire CLOCK_DIVIDE_SEL_HI,
	input wire CLOCK_DIVIDE_SEL_LO,
	input wire OSCILLATOR_INPUT,
	input wire CARD_DETECT_IN,
	// supervisor inputs
	input wire LOGIC_SUPPLY_FAULT,
	input wire CARD_OVERCURRENT,
	input wire CARD_VCC_VALID,
	// card side outputs
	output reg CARD_VCC_EN,
	output reg CARD_VCC_5V_SEL,
	output reg CARD_RST,
	output reg CARD_CLK,
	// card i/o line
	input wire CARD_IO_I,
	output wire CARD_IO_O,
	output wire CARD_IO_OE,
	// host i/o line
	input wire HOST_IO_I,
	output wire HOST_IO_O,
	output wire HOST_IO_OE,
	// open-drain status line, low means no card or fault
	output wire STATUS_OFF_N_O,
	output reg STATUS_OFF_N_OE
);

// ----------------------------------------------------------------
// states and sized constants
// ----------------------------------------------------------------
localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_ACT1 = 4'h1;
localparam [3:0] S_ACT2 = 4'h2;
localparam [3:0] S_ACT3 = 4'h3;
localparam [3:0] S_WRST = 4'h4;
localparam [3:0] S_ON = 4'h5;
localparam [3:0] S_DE1 = 4'h6;
localparam [3:0] S_DE2 = 4'h7;
localparam [3:0] S_DE3 = 4'h8;
localparam [3:0] S_DE4 = 4'h9;
localparam [31:0] HOLD_LAST = HOLDOFF_CYCLES - 1;
localparam [31:0] STEP_LAST = STEP_OSC_CYCLES - 1;

// ----------------------------------------------------------------
// pin synchronisation
// ----------------------------------------------------------------
wire [`SYNC_W-1:0] pins;
wire [`SYNC_W-1:0] pins_s;
assign pins[`B_ACT] = ACTIVATION_REQUEST_N;
assign pins[`B_RSTREQ] = CARD_RESET_REQUEST_IN;
assign pins[`B_VSEL] = CARD_VOLTAGE_SELECT;
assign pins[`B_DIV_HI] = CLOCK_DIVIDE_SEL_HI;
assign pins[`B_DIV_LO] = CLOCK_DIVIDE_SEL_LO;
assign pins[`B_OSC] = OSCILLATOR_INPUT;
assign pins[`B_DET] = CARD_DETECT_IN;
assign pins[`B_LOGIC_SUPPLY_FAULT_THRESHOLD] = LOGIC_SUPPLY_FAULT;
assign pins[`B_OC] = CARD_OVERCURRENT;
assign pins[`B_VCCOK] = CARD_VCC_VALID;
assign pins[`B_CIO] = CARD_IO_I;
assign pins[`B_HIO] = HOST_IO_I;

pin_sync u_sync (
	.clk(CORE_CLK),
	.rst_n(RST_N),
	.pins(pins),
	.pins_s(pins_s)
);

wire act_n = pins_s[`B_ACT];
wire rst_req = pins_s[`B_RSTREQ];
wire osc = pins_s[`B_OSC];
wire det = pins_s[`B_DET];
wire logic_supply_fault_threshold = pins_s[`B_LOGIC_SUPPLY_FAULT_THRESHOLD];
wire [1:0] div_sel = {pins_s[`B_DIV_HI], pins_s[`B_DIV_LO]};

// ----------------------------------------------------------------
// edge detection on synchronised levels
// ----------------------------------------------------------------
reg act_prev_q;
reg rst_prev_q;
reg osc_prev_q;
reg det_prev_q;
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		act_prev_q <= 1'b1;
		rst_prev_q <= 1'b0;
		osc_prev_q <= 1'b0;
		det_prev_q <= 1'b0;
	end else begin
		act_prev_q <= act_n;
		rst_prev_q <= rst_req;
		osc_prev_q <= osc;
		det_prev_q <= det;
	end
end
wire act_fall = act_prev_q & ~act_n;
wire rst_fall = rst_prev_q & ~rst_req;
wire osc_rise = ~osc_prev_q & osc;
wire det_change = det_prev_q ^ det;

// ----------------------------------------------------------------
// card clock divider
// ----------------------------------------------------------------
// the oscillator is sampled, so it must stay well below half of CORE_CLK
reg [1:0] div_cnt_q;
reg div_clk_q;
reg div_tog;
always @* begin
	case (div_sel)
		`DIV2: div_tog = 1'b1;
		`DIV4: div_tog = div_cnt_q[0];
		`DIV8: div_tog = &div_cnt_q;
		default: div_tog = 1'b0;
	endcase
end

always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		div_cnt_q <= 2'h0;
		div_clk_q <= 1'b0;
	end else if (osc_rise) begin
		div_cnt_q <= div_cnt_q + 2'h1;
		if (div_tog) begin
			div_clk_q <= ~div_clk_q;
		end
	end
end

// ----------------------------------------------------------------
// power-up hold-off
// ----------------------------------------------------------------
// restarts whenever the logic supply drops below its threshold
reg [18:0] hold_cnt_q;
reg hold_done_q;
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		hold_cnt_q <= 19'h00000;
		hold_done_q <= 1'b0;
	end else if (logic_supply_fault_threshold) begin
		hold_cnt_q <= 19'h00000;
		hold_done_q <= 1'b0;
	end else if (!hold_done_q) begin
		hold_cnt_q <= hold_cnt_q + 19'h00001;
		if ({13'h0000, hold_cnt_q} == HOLD_LAST) begin
			hold_done_q <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// register file state
// ----------------------------------------------------------------
reg [`STAT_W-1:0] stat_q;
reg [`STAT_W-1:0] mask_q;
reg inhibit_q;

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
reg [3:0] state_q;
reg [3:0] state_d;
reg [15:0] step_cnt_q;
reg rst_at_start_q;
reg fault_q;
reg vcc_en_q;
reg vsel_q;
reg io_rx_q;
reg clk_en_q;
reg rst_out_q;

wire step_done = osc_rise & ({16'h0000, step_cnt_q} == STEP_LAST);
wire in_session = (state_q != S_IDLE) && (state_q < S_DE1);
wire card_fault = logic_supply_fault_threshold | pins_s[`B_OC] | ~det;
wire vcc_bad = ~pins_s[`B_VCCOK] & (state_q >= S_ACT2) & (state_q <= S_ON);
wire auto_deact = in_session & (card_fault | vcc_bad);
wire may_start = act_fall & det & ~logic_supply_fault_threshold & hold_done_q & ~inhibit_q;
wire vcc_fail = (state_q == S_ACT1) & step_done & ~pins_s[`B_VCCOK];

// next state: a high request or any fault except the VCC check after the first interval (back to idle) leaves the session by the same path
always @* begin
	state_d = state_q;
	case (state_q)
		S_IDLE: begin
			if (may_start) begin
				state_d = S_ACT1;
			end
		end
		S_ACT1: begin
			if (vcc_fail) begin
				state_d = S_IDLE;
			end else if (step_done) begin
				state_d = rst_at_start_q ? S_WRST : S_ACT2;
			end
		end
		S_ACT2: begin
			if (step_done) begin
				state_d = S_ACT3;
			end
		end
		S_ACT3: begin
			if (step_done) begin
				state_d = S_ON;
			end
		end
		S_WRST: begin
			if (rst_fall) begin
				state_d = S_ON;
			end
		end
		S_ON: state_d = S_ON;
		S_DE1, S_DE2, S_DE3: begin
			if (step_done) begin
				state_d = state_q + 4'h1;
			end
		end
		S_DE4: begin
			if (step_done) begin
				state_d = S_IDLE;
			end
		end
		default: state_d = S_IDLE;
	endcase
	if (in_session && !vcc_fail && (act_n || auto_deact)) begin
		state_d = S_DE1;
	end
end

// interval counter restarts on every state change
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		state_q <= S_IDLE;
		step_cnt_q <= 16'h0000;
	end else begin
		state_q <= state_d;
		if (state_d != state_q || step_done) begin
			step_cnt_q <= 16'h0000;
		end else if (osc_rise) begin
			step_cnt_q <= step_cnt_q + 16'h0001;
		end
	end
end

// card signal controls, driven per step
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		rst_at_start_q <= 1'b0;
		vcc_en_q <= 1'b0;
		vsel_q <= 1'b0;
		io_rx_q <= 1'b0;
		clk_en_q <= 1'b0;
		rst_out_q <= 1'b0;
	end else begin
		if (state_q == S_IDLE && state_d == S_ACT1) begin
			rst_at_start_q <= rst_req;
			vcc_en_q <= 1'b1;
			vsel_q <= pins_s[`B_VSEL];
		end
		if (vcc_fail) begin
			vcc_en_q <= 1'b0;
		end
		if (state_q == S_ACT1 && (state_d == S_ACT2 || state_d == S_WRST)) begin
			io_rx_q <= 1'b1;
		end
		if (state_q == S_ACT3 && state_d == S_ON) begin
			clk_en_q <= 1'b1;
		end
		if (state_q == S_WRST && state_d == S_ON) begin
			clk_en_q <= 1'b1;
		end
		if (state_q == S_ON) begin
			rst_out_q <= rst_req;
		end
		if (state_q == S_DE1 && step_done) begin
			rst_out_q <= 1'b0;
		end
		if (state_q == S_DE2 && step_done) begin
			clk_en_q <= 1'b0;
		end
		if (state_q == S_DE3 && step_done) begin
			io_rx_q <= 1'b0;
		end
		if (state_q == S_DE4 && step_done) begin
			vcc_en_q <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// fault latch and status line
// ----------------------------------------------------------------
// faults count only inside a session; cleared once the host drops the request
wire fault_set = auto_deact | vcc_fail;
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		fault_q <= 1'b0;
		STATUS_OFF_N_OE <= 1'b1;
	end else begin
		if (fault_set) begin
			fault_q <= 1'b1;
		end else if (state_q == S_IDLE && act_n) begin
			fault_q <= 1'b0;
		end
		STATUS_OFF_N_OE <= fault_set | fault_q | ~det;
	end
end
assign STATUS_OFF_N_O = 1'b0;

// ----------------------------------------------------------------
// card pin registers
// ----------------------------------------------------------------
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		CARD_VCC_EN <= 1'b0;
		CARD_VCC_5V_SEL <= 1'b0;
		CARD_RST <= 1'b0;
		CARD_CLK <= 1'b0;
	end else begin
		CARD_VCC_EN <= vcc_en_q;
		CARD_VCC_5V_SEL <= vsel_q;
		CARD_RST <= rst_out_q;
		if (!clk_en_q) begin
			CARD_CLK <= 1'b0;
		end else if (div_sel == `DIV1) begin
			CARD_CLK <= osc;
		end else begin
			CARD_CLK <= div_clk_q;
		end
	end
end

// ----------------------------------------------------------------
// i/o line direction
// ----------------------------------------------------------------
io_direction u_io (
	.clk(CORE_CLK),
	.rst_n(RST_N),
	.rx_en(io_rx_q), // stays on until the third deactivation step
	.card_in(pins_s[`B_CIO]),
	.host_in(pins_s[`B_HIO]),
	.card_oe(CARD_IO_OE),
	.host_oe(HOST_IO_OE)
);
assign CARD_IO_O = 1'b0;
assign HOST_IO_O = 1'b0;

// ----------------------------------------------------------------
// events, register port and interrupt
// ----------------------------------------------------------------
wire [`STAT_W-1:0] ev;
assign ev[`EV_ACT] = (state_q != S_ON) & (state_d == S_ON);
assign ev[`EV_DEACT] = (state_q == S_DE4) & (state_d == S_IDLE);
assign ev[`EV_FAULT] = fault_set & ~fault_q;
assign ev[`EV_CARD] = det_change;
wire wr_stat = REG_WR & (REG_ADDR == `A_STAT);

// a new event wins over a write-one-to-clear in the same cycle
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		stat_q <= 4'h0;
		mask_q <= 4'h0;
		inhibit_q <= 1'b0;
		IRQ <= 1'b0;
	end else begin
		stat_q <= (stat_q & ~(wr_stat ? REG_WDATA[`STAT_W-1:0] : 4'h0)) | ev;
		if (REG_WR && REG_ADDR == `A_MASK) begin
			mask_q <= REG_WDATA[`STAT_W-1:0];
		end
		if (REG_WR && REG_ADDR == `A_CTRL) begin
			inhibit_q <= REG_WDATA[`CTRL_INHIBIT];
		end
		IRQ <= |(stat_q & mask_q);
	end
end

// read data stand only in the cycle after the strobe
always @(posedge CORE_CLK or negedge RST_N) begin
	if (!RST_N) begin
		REG_RDATA <= 8'h00;
	end else if (REG_RD) begin
		case (REG_ADDR)
			`A_STAT: REG_RDATA <= {4'h0, stat_q};
			`A_MASK: REG_RDATA <= {4'h0, mask_q};
			`A_STATE: REG_RDATA <= {io_rx_q, clk_en_q, vcc_en_q, hold_done_q, state_q};
			`A_CTRL: REG_RDATA <= {7'h00, inhibit_q};
			default: REG_RDATA <= 8'h00;
		endcase
	end else begin
		REG_RDATA <= 8'h00;
	end
end

endmodule

// ---- rtl/io_direction.v ----
// direction arbiter between card i/o line and host i/o line
`timescale 1ns/1ps

module io_direction (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// reception enable from the sequencer
	input wire rx_en,
	// synchronised line levels
	input wire card_in,
	input wire host_in,
	// open-drain drive enables (driving pulls the line low)
	output reg card_oe,
	output reg host_oe
);

localparam [1:0] NEUT = 2'h0;
localparam [1:0] CARD_IN = 2'h1;
localparam [1:0] HOST_IN = 2'h2;

reg [1:0] dir_q;
reg [1:0] dir_d;
reg c_prev_q;
reg h_prev_q;
wire c_fall = c_prev_q & ~card_in;
wire h_fall = h_prev_q & ~host_in;
wire c_rise = ~c_prev_q & card_in;
wire h_rise = ~h_prev_q & host_in;

// first falling edge picks the input line; card wins a tie
always @* begin
	dir_d = dir_q;
	case (dir_q)
		NEUT: begin
			if (c_fall) begin
				dir_d = CARD_IN;
			end else if (h_fall) begin
				dir_d = HOST_IN;
			end
		end
		CARD_IN: begin
			if (c_rise) begin
				dir_d = NEUT;
			end
		end
		HOST_IN: begin
			if (h_rise) begin
				dir_d = NEUT;
			end
		end
		default: dir_d = NEUT;
	endcase
	if (!rx_en) begin
		dir_d = NEUT;
	end
end

// the output line copies the input line; our own echo is ignored by state
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		dir_q <= NEUT;
		c_prev_q <= 1'b0;
		h_prev_q <= 1'b1;
		card_oe <= 1'b1;
		host_oe <= 1'b0;
	end else begin
		dir_q <= dir_d;
		c_prev_q <= card_in;
		h_prev_q <= host_in;
		card_oe <= ~rx_en | ((dir_d == HOST_IN) & ~host_in);
		host_oe <= rx_en & (dir_d == CARD_IN) & ~card_in;
	end
end

endmodule

// ---- rtl/pin_sync.v ----
// two flip-flop synchronisers for every pin input of the sequencer
`timescale 1ns/1ps
`include "card_seq_defs.vh"

module pin_sync (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// raw pins and their synchronised copies
	input wire [`SYNC_W-1:0] pins,
	output wire [`SYNC_W-1:0] pins_s
);

localparam [`SYNC_W-1:0] INIT = `SYNC_INIT;

genvar i;
generate
	for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
		reg meta_q;
		reg sync_q;
		// first stage feeds only the second; reset to the pull level of each pin
		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q <= INIT[i];
				sync_q <= INIT[i];
			end else begin
				meta_q <= pins[i];
				sync_q <= meta_q;
			end
		end
		assign pins_s[i] = sync_q;
	end
endgenerate

endmodule
